// >>> src/rpf_consts.vh
// Constants for the ROM patch fetch substitution block
`ifndef RPF_CONSTS_VH
`define RPF_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define RPF_OFS_CONTROL    4'h0
`define RPF_OFS_ADDR_LOW   4'h1
`define RPF_OFS_ADDR_HIGH  4'h2
`define RPF_ADDR_W         4
`define RPF_DATA_W         16

// ****************************************
// Control fields and reset values
// ****************************************
`define RPF_CTL_SEL_LSB    0
`define RPF_CTL_SEL_MSB    1
`define RPF_CTL_EN_LSB     4
`define RPF_CTL_EN_MSB     7
`define RPF_CTL_WMASK      8'hf3
`define RPF_CTL_RESET      8'h00
`define RPF_PTR_RESET      24'h000000

// ****************************************
// Fetch path and substitution codes
// ****************************************
`define RPF_FETCH_AW       24
`define RPF_CHANNELS       4
`define RPF_OPC_BASE       8'hfc
`define RPF_TABLE_BASE     16'h0078

`endif

// >>> src/rpf_channel_match.v
// One patch channel: address pointer and its comparator
`timescale 1ns/1ps

module rpf_channel_match (
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire        load_low_i,
    input  wire        load_high_i,
    input  wire [15:0] wdata_i,
    input  wire [23:0] fetch_addr_i,
    input  wire        enable_i,
    output wire [23:0] pointer_o,
    output wire        hit_o
);

`include "rpf_consts.vh"

    reg [23:0] pointer;

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pointer <= `RPF_PTR_RESET;
        end else begin
            if (load_low_i) begin
                pointer[15:0] <= wdata_i;
            end
            if (load_high_i) begin
                pointer[23:16] <= wdata_i[7:0];
            end
        end
    end

    assign pointer_o = pointer;
    // RULE_02 comparator per access
    assign hit_o = enable_i && (pointer == fetch_addr_i);

endmodule

// >>> src/rpf_patch_top.v
// ROM patch unit: four pointers substituting table-call opcodes on fetch
//
// How it works
// RULE_01 - Four independent channels each hold one repair address.
// RULE_02 - Every channel compares its address with each internal ROM access address.
// RULE_03 - Matching applies only to opcode fetches from internal ROM, never data reads.
// RULE_04 - On a match the ROM byte is dropped and the table-call opcode is sent instead.
// RULE_05 - Channel 0..3 gives opcode fch, fdh, feh, ffh respectively.
// RULE_06 - The opcodes vector via table entries 0078h, 007ah, 007ch, 007eh.
// RULE_07 - No status flag records that a substitution took place.
// RULE_08 - Software never programs one address into two enabled channels.
// RULE_09 - Software programs the address of an instruction's first opcode byte.
// RULE_10 - Software keeps the four table entries free while patching is used.
// RULE_11 - Control bits 7:4 enable matching for channels 3..0.
// RULE_12 - Control bits 1:0 pick the channel that address writes load.
// RULE_13 - Reset clears the control register, disabling all and selecting channel 0.
`timescale 1ns/1ps

module rpf_patch_top (
    input  wire        clk_sys_i,
    input  wire        resetn_i,
    input  wire [3:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [15:0] reg_rdata_o,
    input  wire [23:0] fetch_addr_i,
    input  wire        fetch_opcode_i,
    input  wire        fetch_rom_i,
    input  wire [7:0]  rom_data_i,
    output reg  [7:0]  fetch_data_o,
    output reg         patch_hit_o,
    output reg  [15:0] patch_vector_o
);

`include "rpf_consts.vh"

    // ****************************************
    // Reset release
    // ****************************************
    reg        rst_meta;
    reg        rst_n;

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    reg  [7:0] patch_control;
    wire [1:0] patch_channel_select;
    wire [3:0] patch_match_enable;

    assign patch_channel_select = patch_control[`RPF_CTL_SEL_MSB:`RPF_CTL_SEL_LSB];
    assign patch_match_enable   = patch_control[`RPF_CTL_EN_MSB:`RPF_CTL_EN_LSB];

    // RULE_13 reset clears control
    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            patch_control <= `RPF_CTL_RESET;
        end else if (reg_wr_i && reg_addr_i == `RPF_OFS_CONTROL) begin
            patch_control <= reg_wdata_i[7:0] & `RPF_CTL_WMASK;
        end
    end

    // ****************************************
    // Channels
    // ****************************************
    wire [3:0]  hit;
    wire [95:0] pointers;
    wire        wr_low;
    wire        wr_high;
    wire [3:0]  load_low;
    wire [3:0]  load_high;

    // Write strobe routed to one channel only
    function ch_pick;
        input       strobe;
        input [1:0] sel;
        input [1:0] ch;
        begin
            ch_pick = strobe && (sel == ch);
        end
    endfunction

    // RULE_12 selected channel loads
    assign wr_low       = reg_wr_i && (reg_addr_i == `RPF_OFS_ADDR_LOW);
    assign wr_high      = reg_wr_i && (reg_addr_i == `RPF_OFS_ADDR_HIGH);
    assign load_low[0]  = ch_pick(wr_low, patch_channel_select, 2'd0);
    assign load_low[1]  = ch_pick(wr_low, patch_channel_select, 2'd1);
    assign load_low[2]  = ch_pick(wr_low, patch_channel_select, 2'd2);
    assign load_low[3]  = ch_pick(wr_low, patch_channel_select, 2'd3);
    assign load_high[0] = ch_pick(wr_high, patch_channel_select, 2'd0);
    assign load_high[1] = ch_pick(wr_high, patch_channel_select, 2'd1);
    assign load_high[2] = ch_pick(wr_high, patch_channel_select, 2'd2);
    assign load_high[3] = ch_pick(wr_high, patch_channel_select, 2'd3);

    // RULE_01 four channels
    rpf_channel_match u_match_0 (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n),
        .load_low_i   (load_low[0]),
        .load_high_i  (load_high[0]),
        .wdata_i      (reg_wdata_i),
        .fetch_addr_i (fetch_addr_i),
        // RULE_11 per-channel enable
        .enable_i     (patch_match_enable[0]),
        .pointer_o    (pointers[23:0]),
        .hit_o        (hit[0])
    );

    rpf_channel_match u_match_1 (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n),
        .load_low_i   (load_low[1]),
        .load_high_i  (load_high[1]),
        .wdata_i      (reg_wdata_i),
        .fetch_addr_i (fetch_addr_i),
        // RULE_11 per-channel enable
        .enable_i     (patch_match_enable[1]),
        .pointer_o    (pointers[47:24]),
        .hit_o        (hit[1])
    );

    rpf_channel_match u_match_2 (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n),
        .load_low_i   (load_low[2]),
        .load_high_i  (load_high[2]),
        .wdata_i      (reg_wdata_i),
        .fetch_addr_i (fetch_addr_i),
        // RULE_11 per-channel enable
        .enable_i     (patch_match_enable[2]),
        .pointer_o    (pointers[71:48]),
        .hit_o        (hit[2])
    );

    rpf_channel_match u_match_3 (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n),
        .load_low_i   (load_low[3]),
        .load_high_i  (load_high[3]),
        .wdata_i      (reg_wdata_i),
        .fetch_addr_i (fetch_addr_i),
        // RULE_11 per-channel enable
        .enable_i     (patch_match_enable[3]),
        .pointer_o    (pointers[95:72]),
        .hit_o        (hit[3])
    );

    // ****************************************
    // Substitution
    // ****************************************
    // Lowest channel wins; duplicate addresses are a software fault
    function [1:0] first_hit;
        input [3:0] h;
        begin
            first_hit = h[0] ? 2'd0 : h[1] ? 2'd1 : h[2] ? 2'd2 : 2'd3;
        end
    endfunction

    // RULE_05 one opcode per channel
    function [7:0] table_opcode;
        input [1:0] ch;
        begin
            table_opcode = `RPF_OPC_BASE | {6'h00, ch};
        end
    endfunction

    // RULE_06 two bytes per table entry
    function [15:0] table_vector;
        input [1:0] ch;
        begin
            table_vector = `RPF_TABLE_BASE + {13'h0000, ch, 1'b0};
        end
    endfunction

    wire       fetch_ok;
    wire       any_hit;
    wire [1:0] hit_ch;

    // RULE_03 opcode fetch from ROM only
    assign fetch_ok = fetch_opcode_i && fetch_rom_i;
    assign any_hit  = fetch_ok && (hit != 4'h0);
    assign hit_ch   = first_hit(hit);

    // Registered: data reaches the CPU one cycle after the address.
    // RULE_07 hit is a live pulse, not a sticky flag
    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            fetch_data_o   <= 8'h00;
            patch_hit_o    <= 1'b0;
            patch_vector_o <= 16'h0000;
        end else begin
            patch_hit_o <= any_hit;
            // RULE_04 RULE_05 opcode substitution
            if (any_hit) begin
                fetch_data_o <= table_opcode(hit_ch);
            end else begin
                fetch_data_o <= rom_data_i;
            end
            // RULE_06 table entry of the channel
            patch_vector_o <= table_vector(hit_ch);
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    wire [23:0] sel_ptr;

    assign sel_ptr = pointers[patch_channel_select*24 +: 24];

    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `RPF_OFS_CONTROL:   reg_rdata_o <= {8'h00, patch_control};
                `RPF_OFS_ADDR_LOW:  reg_rdata_o <= sel_ptr[15:0];
                `RPF_OFS_ADDR_HIGH: reg_rdata_o <= {8'h00, sel_ptr[23:16]};
                default:            reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

endmodule

// >>> testbench/rpf_patch_props.sv
// Port checker for the ROM patch unit
`timescale 1ns/1ps
module rpf_patch_props (
    input logic        clk_sys_i,
    input logic        resetn_i,
    input logic [3:0]  reg_addr_i,
    input logic [15:0] reg_wdata_i,
    input logic        reg_wr_i,
    input logic        reg_rd_i,
    input logic [15:0] reg_rdata_o,
    input logic [23:0] fetch_addr_i,
    input logic        fetch_opcode_i,
    input logic        fetch_rom_i,
    input logic [7:0]  rom_data_i,
    input logic [7:0]  fetch_data_o,
    input logic        patch_hit_o,
    input logic [15:0] patch_vector_o
);
    // Internal reset lags two edges, so wait three
    logic [1:0] up;
    always_ff @(posedge clk_sys_i or negedge resetn_i)
        if (!resetn_i) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i || up != 2'h3);
    sequence s_rom_fetch; fetch_opcode_i && fetch_rom_i; endsequence
    property p_opc; patch_hit_o |-> fetch_data_o[7:2] == 6'h3f; endproperty
    a_opc: assert property (p_opc) else $error("bad opcode");
    property p_vec;
        patch_hit_o |-> patch_vector_o == 16'h0078 + {fetch_data_o[1:0], 1'b0};
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_tbl; s_rom_fetch ##1 patch_hit_o |-> patch_vector_o[15:3] == 13'h000f; endproperty
    a_tbl: assert property (p_tbl) else $error("vector off table");
    property p_data;
        !fetch_opcode_i |=> !patch_hit_o && fetch_data_o == $past(rom_data_i);
    endproperty
    a_data: assert property (p_data) else $error("data read patched");
    property p_ext;
        !fetch_rom_i |=> !patch_hit_o && fetch_data_o == $past(rom_data_i);
    endproperty
    a_ext: assert property (p_ext) else $error("non-rom fetch patched");
    property p_pass; !patch_hit_o |-> fetch_data_o == $past(rom_data_i); endproperty
    a_pass: assert property (p_pass) else $error("rom byte altered");
    property p_idle; !reg_rd_i |=> reg_rdata_o == 16'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not cleared");
    property p_unmap; reg_rd_i && reg_addr_i > 4'h2 |=> reg_rdata_o == 16'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_ctl;
        reg_rd_i && reg_addr_i == 4'h0 |=>
            reg_rdata_o[15:8] == 8'h0 && reg_rdata_o[3:2] == 2'h0;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control fixed bits");
endmodule
bind rpf_patch_top rpf_patch_props u_props (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .fetch_addr_i(fetch_addr_i), .fetch_opcode_i(fetch_opcode_i),
    .fetch_rom_i(fetch_rom_i), .rom_data_i(rom_data_i), .fetch_data_o(fetch_data_o),
    .patch_hit_o(patch_hit_o), .patch_vector_o(patch_vector_o));

// >>> testbench/rpf_fetch_model.sv
// CPU fetch side model driving the ROM fetch port
`timescale 1ns/1ps
module rpf_fetch_model (
    input  logic        clk_sys_i,
    output logic [23:0] fetch_addr_o = 24'h0,
    output logic        fetch_opcode_o = 1'b0,
    output logic        fetch_rom_o = 1'b0,
    output logic [7:0]  rom_data_o = 8'h00
);
    // table entries never fetched as code
    task automatic fetch(input logic [23:0] a, input logic op, input logic rom);
        @(posedge clk_sys_i);
        fetch_addr_o <= a;
        fetch_opcode_o <= op;
        fetch_rom_o <= rom;
        rom_data_o <= a[7:0] ^ 8'h5a;
        @(posedge clk_sys_i);
        fetch_opcode_o <= 1'b0;
        // Stale byte inverted so it cannot pass by luck
        rom_data_o <= ~(a[7:0] ^ 8'h5a);
    endtask
endmodule

// >>> testbench/rpf_patch_top_tb.sv
// Self-checking bench for the ROM patch unit
`timescale 1ns/1ps
module rpf_patch_top_tb;
    logic        clk_sys_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0, reg_rdata_o, patch_vector_o;
    logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, fetch_opcode_i, fetch_rom_i, patch_hit_o;
    logic [23:0] fetch_addr_i;
    logic [7:0]  rom_data_i, fetch_data_o;
    int          fail_count = 0, checks = 0;
    initial forever #10 clk_sys_i = ~clk_sys_i;
    rpf_patch_top DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .fetch_addr_i(fetch_addr_i), .fetch_opcode_i(fetch_opcode_i),
        .fetch_rom_i(fetch_rom_i), .rom_data_i(rom_data_i), .fetch_data_o(fetch_data_o),
        .patch_hit_o(patch_hit_o), .patch_vector_o(patch_vector_o));
    rpf_fetch_model cpu (.clk_sys_i(clk_sys_i), .fetch_addr_o(fetch_addr_i),
        .fetch_opcode_o(fetch_opcode_i), .fetch_rom_o(fetch_rom_i), .rom_data_o(rom_data_i));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
    endtask
    // distinct pointers
    // Distinct pointers, so no two enabled channels share one
    function automatic logic [23:0] pa(input int c);
        return {8'h10 + c[7:0], 16'h2000 + 16'h0104 * c[15:0]};
    endfunction
    task automatic fc(input logic [23:0] a, input logic op, rom, h, input logic [1:0] c);
        cpu.fetch(a, op, rom);
        #1 chk({8'h0, fetch_data_o}, h ? {14'h3f, c} : {8'h0, a[7:0] ^ 8'h5a});
        chk({15'h0, patch_hit_o}, {15'h0, h});
        if (h) chk(patch_vector_o, 16'h0078 + {c, 1'b0});
    endtask
    task automatic t_reset;
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0000);
    endtask
    task automatic t_regs;
        logic [23:0] p;
        for (int c = 0; c < 4; c++) begin
            p = pa(c);
            wr(4'h0, c[15:0]);
            wr(4'h1, p[15:0]);
            wr(4'h2, {8'h0, p[23:16]});
        end
        for (int c = 0; c < 4; c++) begin
            p = pa(c);
            wr(4'h0, c[15:0]);
            rd(4'h1, p[15:0]);
            rd(4'h2, {8'h0, p[23:16]});
        end
        wr(4'h0, 16'h00ff);
        wr(4'h5, 16'hffff);
        rd(4'h5, 16'h0000);
        // Unmapped write must leave channel 3 alone
        rd(4'h1, p[15:0]);
        rd(4'h0, 16'h00f3);
    endtask
    task automatic t_match;
        for (int c = 0; c < 4; c++) fc(pa(c), 1'b1, 1'b1, 1'b1, c[1:0]);
        fc(pa(1) + 24'h1, 1'b1, 1'b1, 1'b0, 2'h0);
        fc(pa(2), 1'b0, 1'b1, 1'b0, 2'h0);
        fc(pa(2), 1'b1, 1'b0, 1'b0, 2'h0);
        rd(4'h0, 16'h00f3);
        wr(4'h0, 16'h0020);
        fc(pa(0), 1'b1, 1'b1, 1'b0, 2'h0);
        fc(pa(1), 1'b1, 1'b1, 1'b1, 2'h1);
    endtask
    task automatic finish_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        t_reset;
        t_regs;
        t_match;
        finish_test;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #200000;
        fail_count++;
        finish_test;
    end
endmodule
